// [sprf_line_model.sv]
// Behavioural remote serial node on the character side of the register interface.
// Assumes the same system clock; the bench calls its tasks to inject received frames.
module sprf_line_model (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic tx_start,
   input wire logic [8:0] tx_char,
   output logic tx_shift_done,
   output logic rx_frame_valid,
   output logic [8:0] rx_frame_data,
   output logic rx_frame_stop,
   output logic rx_frame_perr,
   output logic rx_start_seen
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [8:0] tx_seen [$];
   int lat = 3;
   int cnt = 0;
   initial begin
      tx_shift_done = 1'b0;
      rx_frame_valid = 1'b0;
      rx_frame_data = 9'h155;
      rx_frame_stop = 1'b0;
      rx_frame_perr = 1'b1;
      rx_start_seen = 1'b0;
   end
   // Shift time is set by the bench, so a slow line can hold a second character buffered
   always @(posedge clock) begin
      tx_shift_done <= 1'b0;
      if (cnt == 1) begin
         tx_shift_done <= 1'b1;
      end
      if (cnt > 0) begin
         cnt <= cnt - 1;
      end
      if (tx_start === 1'b1) begin
         tx_seen.push_back(tx_char);
         cnt <= lat;
      end
   end
   // Released frame lines show the inverse, never a stale copy of the last frame
   task send_frame(input logic [8:0] d, input logic stop, input logic perr);
      @(posedge clock);
      rx_frame_valid <= 1'b1;
      rx_frame_data <= d;
      rx_frame_stop <= stop;
      rx_frame_perr <= perr;
      @(posedge clock);
      rx_frame_valid <= 1'b0;
      rx_frame_data <= ~d;
      rx_frame_stop <= ~stop;
      rx_frame_perr <= ~perr;
   endtask
   task start_bit;
      @(posedge clock);
      rx_start_seen <= 1'b1;
      @(posedge clock);
      rx_start_seen <= 1'b0;
   endtask
endmodule

// [sprf_pkg.sv]
// Constants, register map and carrier types of the serial port register interface.
// Assumes a single system clock and a simple strobe register port.
package sprf_pkg;
   localparam logic [1:0] SPRF_ADDR_DATA = 2'h0;
   localparam logic [1:0] SPRF_ADDR_STA = 2'h1;
   localparam logic [1:0] SPRF_ADDR_CTB = 2'h2;
   localparam logic [1:0] SPRF_ADDR_SHARED = 2'h3;
   localparam int SPRF_RX_DONE_POS = 7;
   localparam int SPRF_TX_DONE_POS = 6;
   localparam int SPRF_TX_EMPTY_POS = 5;
   localparam int SPRF_FRAME_ERR_POS = 4;
   localparam int SPRF_OVERRUN_POS = 3;
   localparam int SPRF_PARITY_ERR_POS = 2;
   localparam int SPRF_DOUBLE_SPEED_POS = 1;
   localparam int SPRF_ADDR_FILTER_POS = 0;
   localparam int SPRF_RX_DONE_IE_POS = 7;
   localparam int SPRF_TX_DONE_IE_POS = 6;
   localparam int SPRF_TX_EMPTY_IE_POS = 5;
   localparam int SPRF_RX_ENABLE_POS = 4;
   localparam int SPRF_TX_ENABLE_POS = 3;
   localparam int SPRF_CSZ2 = 2;
   localparam int SPRF_RX_NINTH_POS = 1;
   localparam int SPRF_TX_NINTH_POS = 0;
   localparam int SPRF_SEL = 7;
   localparam int SPRF_PARITY_EN_POS = 5;
   localparam logic [7:0] SPRF_STA_RESET = 8'h20;
   localparam logic [7:0] SPRF_CTB_RESET = 8'h00;
   localparam logic [7:0] SPRF_FRC_RESET = 8'h86;
   localparam logic [3:0] SPRF_DIVH_RESET = 4'h0;
   localparam logic [4:0] SPRF_DIV_NORMAL = 5'h10;
   localparam logic [4:0] SPRF_DIV_DOUBLE = 5'h08;
   typedef struct packed {
      logic [1:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } sprf_bus_t;
   typedef struct packed {
      logic [8:0] data;
      logic frame_err;
      logic parity_err;
      logic overrun;
   } sprf_rxent_t;
endpackage

// [sprf_rx_fifo.sv]
// Two-entry receive FIFO; head output is a combinational, count-gated copy of the registered oldest entry.
// Assumes push and pop come from the same clock; flush wins over both.
module sprf_rx_fifo
   import sprf_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic flush,
   input wire logic push,
   input wire sprf_rxent_t push_data,
   input wire logic pop,
   output sprf_rxent_t head,
   output logic [1:0] count
);
   sprf_rxent_t mem_r [2];
   sprf_rxent_t mem_nxt [2];
   logic [1:0] cnt_r, cnt_nxt;

   always_comb begin
      mem_nxt = mem_r;
      cnt_nxt = cnt_r;
      if (flush) begin
         cnt_nxt = 2'h0;
      end else begin
         if (pop && cnt_r != 2'h0) begin
            mem_nxt[0] = mem_r[1];
            cnt_nxt = cnt_r - 2'h1;
         end
         if (push && cnt_nxt != 2'h2) begin
            mem_nxt[cnt_nxt[0]] = push_data;
            cnt_nxt = cnt_nxt + 2'h1;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mem_r[0] <= '0;
         mem_r[1] <= '0;
         cnt_r <= 2'h0;
      end else begin
         mem_r <= mem_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Head reads as zero when empty so error flags read clear then
   assign head = (cnt_r != 2'h0) ? mem_r[0] : '0;
   assign count = cnt_r;
endmodule

// [sprf_top.sv]
// Register interface of the serial transceiver: data port, status A, control B, shared location.
// Assumes a character-level line engine outside: it takes tx_char and reports received frames.
module sprf_top
   import sprf_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire sprf_bus_t bus,
   output logic [7:0] rdata,
   input wire logic global_irq_en,
   input wire logic irq_ack_txdone,
   output logic irq_rx_done,
   output logic irq_tx_done,
   output logic irq_tx_empty,
   output logic [4:0] baud_ratio,
   output logic [3:0] baud_divisor_high,
   output logic [7:0] frame_control,
   input wire logic rx_frame_valid,
   input wire logic [8:0] rx_frame_data,
   input wire logic rx_frame_stop,
   input wire logic rx_frame_perr,
   input wire logic rx_start_seen,
   output logic rx_pin_own,
   output logic tx_pin_own,
   output logic tx_start,
   output logic [8:0] tx_char,
   input wire logic tx_shift_done
);
   sprf_rxent_t rx_head, rx_push_data;
   logic [1:0] rx_count;
   logic rx_push, rx_pop, rx_flush;
   logic [7:0] sta_r, sta_nxt, ctb_r, ctb_nxt, frc_r, frc_nxt, rdata_r, rdata_nxt;
   logic [3:0] divh_r, divh_nxt;
   logic shared_rd_r, shared_rd_nxt;
   logic [8:0] txbuf_r, txbuf_nxt, txsh_r, txsh_nxt;
   logic txbuf_full_r, txbuf_full_nxt, txsh_busy_r, txsh_busy_nxt;
   logic transmitter_enable_eff_r, transmitter_enable_eff_nxt, tx_start_r, tx_start_nxt;
   logic pend_valid_r, pend_valid_nxt;
   sprf_rxent_t pend_r, pend_nxt;
   logic ovr_r, ovr_nxt;

   // Mask unused upper bits for five to eight bit characters
   function automatic logic [8:0] size_mask(input logic csz2, input logic [1:0] csz);
      logic [8:0] m;
      m = 9'h0ff;
      if (!csz2) begin
         case (csz)
            2'h0: m = 9'h01f;
            2'h1: m = 9'h03f;
            2'h2: m = 9'h07f;
            default: m = 9'h0ff;
         endcase
      end else begin
         m = 9'h1ff;
      end
      return m;
   endfunction

   logic [8:0] mask;
   logic wr_data, rd_data, wr_sta, wr_ctb, wr_shared, rd_shared;
   logic rx_ok, tx_idle;

   always_comb begin
      mask = size_mask(ctb_r[SPRF_CSZ2], frc_r[2:1]);
      wr_data = bus.wr && bus.addr == SPRF_ADDR_DATA;
      rd_data = bus.rd && bus.addr == SPRF_ADDR_DATA;
      wr_sta = bus.wr && bus.addr == SPRF_ADDR_STA;
      wr_ctb = bus.wr && bus.addr == SPRF_ADDR_CTB;
      wr_shared = bus.wr && bus.addr == SPRF_ADDR_SHARED;
      rd_shared = bus.rd && bus.addr == SPRF_ADDR_SHARED;
      // Frame type bit: ninth bit for nine-bit frames, else first stop bit
      rx_ok = !sta_r[SPRF_ADDR_FILTER_POS] ||
         (ctb_r[SPRF_CSZ2] ? rx_frame_data[8] : rx_frame_stop);
      tx_idle = !txbuf_full_r && !txsh_busy_r;
   end

   // Receive path: a frame waits in the pending slot when the FIFO is full
   always_comb begin
      rx_flush = !ctb_r[SPRF_RX_ENABLE_POS];
      rx_pop = rd_data;
      pend_nxt = pend_r;
      pend_valid_nxt = pend_valid_r;
      rx_push = 1'b0;
      rx_push_data = pend_r;
      ovr_nxt = ovr_r;
      if (pend_valid_r && (rx_count != 2'h2 || rx_pop)) begin
         rx_push = 1'b1;
         pend_valid_nxt = 1'b0;
      end
      // A new frame in the same cycle as a push refills the slot
      if (ctb_r[SPRF_RX_ENABLE_POS] && rx_frame_valid && rx_ok) begin
         pend_nxt.data = rx_frame_data & mask;
         pend_nxt.frame_err = !rx_frame_stop;
         pend_nxt.parity_err = rx_frame_perr && frc_r[SPRF_PARITY_EN_POS];
         pend_nxt.overrun = 1'b0;
         pend_valid_nxt = 1'b1;
      end
      // Overrun is a separate flag, shown at once with the current head and cleared by the next data read
      if (rx_count == 2'h2 && pend_valid_r && !rx_pop && rx_start_seen) begin
         ovr_nxt = 1'b1;
      end
      if (rx_pop) begin
         ovr_nxt = 1'b0;
      end
      if (rx_flush) begin
         pend_valid_nxt = 1'b0;
         ovr_nxt = 1'b0;
      end
   end

   // Transmit path: buffer, shifter handoff and delayed disable
   always_comb begin
      txbuf_nxt = txbuf_r;
      txbuf_full_nxt = txbuf_full_r;
      txsh_nxt = txsh_r;
      txsh_busy_nxt = txsh_busy_r;
      tx_start_nxt = 1'b0;
      transmitter_enable_eff_nxt = transmitter_enable_eff_r;
      if (txsh_busy_r && tx_shift_done) begin
         txsh_busy_nxt = 1'b0;
      end
      if (wr_data && !txbuf_full_r) begin
         txbuf_nxt = {ctb_r[SPRF_TX_NINTH_POS], bus.wdata} & mask;
         txbuf_full_nxt = 1'b1;
      end
      if (transmitter_enable_eff_r && txbuf_full_r && !txsh_busy_nxt) begin
         txsh_nxt = txbuf_r;
         txsh_busy_nxt = 1'b1;
         txbuf_full_nxt = wr_data && !txbuf_full_r;
         tx_start_nxt = 1'b1;
      end
      if (ctb_r[SPRF_TX_ENABLE_POS]) begin
         transmitter_enable_eff_nxt = 1'b1;
      end else if (tx_idle) begin
         transmitter_enable_eff_nxt = 1'b0;
      end
   end

   // Registers and read path
   always_comb begin
      sta_nxt = sta_r;
      ctb_nxt = ctb_r;
      frc_nxt = frc_r;
      divh_nxt = divh_r;
      rdata_nxt = 8'h00;
      shared_rd_nxt = rd_shared;
      if (wr_sta) begin
         sta_nxt[SPRF_DOUBLE_SPEED_POS] = bus.wdata[SPRF_DOUBLE_SPEED_POS];
         sta_nxt[SPRF_ADDR_FILTER_POS] = bus.wdata[SPRF_ADDR_FILTER_POS];
         if (bus.wdata[SPRF_TX_DONE_POS]) begin
            sta_nxt[SPRF_TX_DONE_POS] = 1'b0;
         end
      end
      if (irq_ack_txdone) begin
         sta_nxt[SPRF_TX_DONE_POS] = 1'b0;
      end
      // Set placed last so it wins over a clear in the same cycle
      if (txsh_busy_r && tx_shift_done && !txbuf_full_r) begin
         sta_nxt[SPRF_TX_DONE_POS] = 1'b1;
      end
      if (wr_ctb) begin
         ctb_nxt = bus.wdata;
      end
      ctb_nxt[SPRF_RX_NINTH_POS] = rx_head.data[8];
      if (wr_shared) begin
         if (bus.wdata[SPRF_SEL]) begin
            frc_nxt = bus.wdata;
         end else begin
            divh_nxt = bus.wdata[3:0];
         end
      end
      if (bus.rd) begin
         if (bus.addr == SPRF_ADDR_DATA) begin
            rdata_nxt = rx_head.data[7:0];
         end else if (bus.addr == SPRF_ADDR_STA) begin
            rdata_nxt = sta_r;
            rdata_nxt[SPRF_RX_DONE_POS] = rx_count != 2'h0;
            rdata_nxt[SPRF_TX_EMPTY_POS] = !txbuf_full_r;
            rdata_nxt[SPRF_FRAME_ERR_POS] = rx_head.frame_err;
            rdata_nxt[SPRF_OVERRUN_POS] = ovr_r && rx_count != 2'h0;
            rdata_nxt[SPRF_PARITY_ERR_POS] = rx_head.parity_err;
         end else if (bus.addr == SPRF_ADDR_CTB) begin
            rdata_nxt = ctb_r;
         end else if (shared_rd_r) begin
            rdata_nxt = frc_r;
         end else begin
            rdata_nxt = {4'h0, divh_r};
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sta_r <= SPRF_STA_RESET;
         ctb_r <= SPRF_CTB_RESET;
         frc_r <= SPRF_FRC_RESET;
         divh_r <= SPRF_DIVH_RESET;
         rdata_r <= 8'h00;
         shared_rd_r <= 1'b0;
         txbuf_r <= 9'h000;
         txbuf_full_r <= 1'b0;
         txsh_r <= 9'h000;
         txsh_busy_r <= 1'b0;
         tx_start_r <= 1'b0;
         transmitter_enable_eff_r <= 1'b0;
         pend_r <= '0;
         pend_valid_r <= 1'b0;
         ovr_r <= 1'b0;
      end else begin
         sta_r <= sta_nxt;
         ctb_r <= ctb_nxt;
         frc_r <= frc_nxt;
         divh_r <= divh_nxt;
         rdata_r <= rdata_nxt;
         shared_rd_r <= shared_rd_nxt;
         txbuf_r <= txbuf_nxt;
         txbuf_full_r <= txbuf_full_nxt;
         txsh_r <= txsh_nxt;
         txsh_busy_r <= txsh_busy_nxt;
         tx_start_r <= tx_start_nxt;
         transmitter_enable_eff_r <= transmitter_enable_eff_nxt;
         pend_r <= pend_nxt;
         pend_valid_r <= pend_valid_nxt;
         ovr_r <= ovr_nxt;
      end
   end

   sprf_rx_fifo u_rx_fifo (
      .clock(clock),
      .rst_n(rst_n),
      .flush(rx_flush),
      .push(rx_push),
      .push_data(rx_push_data),
      .pop(rx_pop),
      .head(rx_head),
      .count(rx_count)
   );

   assign rdata = rdata_r;
   assign irq_rx_done = ctb_r[SPRF_RX_DONE_IE_POS] && global_irq_en && rx_count != 2'h0;
   assign irq_tx_done = ctb_r[SPRF_TX_DONE_IE_POS] && global_irq_en && sta_r[SPRF_TX_DONE_POS];
   assign irq_tx_empty = ctb_r[SPRF_TX_EMPTY_IE_POS] && global_irq_en && !txbuf_full_r;
   assign baud_ratio = sta_r[SPRF_DOUBLE_SPEED_POS] ? SPRF_DIV_DOUBLE : SPRF_DIV_NORMAL;
   assign baud_divisor_high = divh_r;
   assign frame_control = frc_r;
   assign rx_pin_own = ctb_r[SPRF_RX_ENABLE_POS];
   assign tx_pin_own = transmitter_enable_eff_r;
   assign tx_start = tx_start_r;
   assign tx_char = txsh_r;

   shared_read_a: assert property (@(posedge clock) disable iff (!rst_n)
      rd_shared && bus.addr == SPRF_ADDR_SHARED && !shared_rd_r |=> rdata == {4'h0, $past(divh_r)})
      else $error("Shared single read did not return divisor high");
   shared_pair_a: assert property (@(posedge clock) disable iff (!rst_n)
      rd_shared ##1 rd_shared |=> rdata == $past(frc_r))
      else $error("Back to back shared read did not return frame control");
   drop_write_a: assert property (@(posedge clock) disable iff (!rst_n)
      wr_data && txbuf_full_r |=> txbuf_r == $past(txbuf_r))
      else $error("Write to full transmit buffer changed it");
   empty_reset_a: assert property (@(posedge clock)
      !rst_n |=> !txbuf_full_r || $past(rst_n))
      else $error("Buffer not empty after reset");
   flush_rx_a: assert property (@(posedge clock) disable iff (!rst_n)
      !ctb_r[SPRF_RX_ENABLE_POS] |=> rx_count == 2'h0)
      else $error("Receive buffer not flushed while disabled");
   txdone_set_a: assert property (@(posedge clock) disable iff (!rst_n)
      txsh_busy_r && tx_shift_done && !txbuf_full_r |=> sta_r[SPRF_TX_DONE_POS])
      else $error("Transmit done lost");
   tx_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
      transmitter_enable_eff_r && !tx_idle |=> tx_pin_own)
      else $error("Transmit pin released with data pending");
   irq_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
      irq_rx_done |-> global_irq_en && ctb_r[SPRF_RX_DONE_IE_POS] && rx_count != 2'h0)
      else $error("Receive interrupt without all its conditions");
   divh_write_a: assert property (@(posedge clock) disable iff (!rst_n)
      wr_shared && !bus.wdata[SPRF_SEL] |=> divh_r == $past(bus.wdata[3:0]) && $stable(frc_r))
      else $error("Shared write went to wrong register");
endmodule

// [sprf_top_tb.sv]
// Self-checking bench of the serial port register interface.
// Assumes the line model stands in for the character-level line engine.
module sprf_top_tb
   import sprf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   sprf_bus_t bus = '0;
   logic global_irq_en = 1'b0;
   logic irq_ack_txdone = 1'b0;
   logic [7:0] rdata, frame_control, a, b, v, v2;
   logic irq_rx_done, irq_tx_done, irq_tx_empty, rx_pin_own, tx_pin_own, tx_start, tx_shift_done;
   logic rx_frame_valid, rx_frame_stop, rx_frame_perr, rx_start_seen;
   logic [4:0] baud_ratio;
   logic [3:0] baud_divisor_high;
   logic [8:0] tx_char, rx_frame_data;
   logic [8:0] rxd [3];
   int n_mismatch = 0;
   int cmp_count = 0;
   int seed = 32'hd29f;
   initial begin
      forever #5 clock = ~clock;
   end
   sprf_top dut (.clock(clock), .rst_n(rst_n), .bus(bus), .rdata(rdata),
      .global_irq_en(global_irq_en), .irq_ack_txdone(irq_ack_txdone),
      .irq_rx_done(irq_rx_done), .irq_tx_done(irq_tx_done), .irq_tx_empty(irq_tx_empty),
      .baud_ratio(baud_ratio),
      .baud_divisor_high(baud_divisor_high), .frame_control(frame_control),
      .rx_frame_valid(rx_frame_valid), .rx_frame_data(rx_frame_data),
      .rx_frame_stop(rx_frame_stop), .rx_frame_perr(rx_frame_perr),
      .rx_start_seen(rx_start_seen), .rx_pin_own(rx_pin_own), .tx_pin_own(tx_pin_own),
      .tx_start(tx_start), .tx_char(tx_char), .tx_shift_done(tx_shift_done));
   sprf_line_model line (.clock(clock), .rst_n(rst_n), .tx_start(tx_start), .tx_char(tx_char),
      .tx_shift_done(tx_shift_done), .rx_frame_valid(rx_frame_valid),
      .rx_frame_data(rx_frame_data), .rx_frame_stop(rx_frame_stop),
      .rx_frame_perr(rx_frame_perr), .rx_start_seen(rx_start_seen));
   task final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task chk(input string name, input logic [8:0] seen, input logic [8:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Idle cycle after each write lets the register update land before any check
   task wr(input logic [1:0] ad, input logic [7:0] d);
      @(posedge clock);
      bus <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clock);
      bus <= '0;
      @(posedge clock);
      #1;
   endtask
   task rchk(input string name, input logic [1:0] ad, input logic [7:0] e);
      @(posedge clock);
      bus <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clock);
      bus <= '0;
      #1;
      chk(name, {1'b0, rdata}, {1'b0, e});
   endtask
   // n above zero waits for that many characters, zero waits for the pin release
   task wait_tx(input int n);
      for (int i = 0; i < 400; i++) begin
         if ((n > 0 && line.tx_seen.size() >= n) || (n == 0 && tx_pin_own === 1'b0)) begin
            return;
         end
         @(posedge clock);
      end
      n_mismatch++;
      $display("unexpected wait_tx expected %0d seen timeout", n);
      final_report();
   endtask
   initial begin
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      rchk("status_a", SPRF_ADDR_STA, 8'h20);
      rchk("control_b", SPRF_ADDR_CTB, 8'h00);
      rchk("divisor_plain", SPRF_ADDR_SHARED, 8'h00);
      chk("baud_ratio", {4'h0, baud_ratio}, 9'd16);
      a = {4'h0, 4'($random(seed))};
      wr(SPRF_ADDR_SHARED, a);
      wr(SPRF_ADDR_SHARED, 8'ha6);
      chk("divisor_high", {5'h00, baud_divisor_high}, {1'b0, a});
      chk("frame_control", {1'b0, frame_control}, 9'h0a6);
      rchk("shared_single", SPRF_ADDR_SHARED, a);
      // Two reads with no gap, nothing in between
      @(posedge clock);
      bus <= '{addr: SPRF_ADDR_SHARED, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clock);
      #1;
      v = rdata;
      @(posedge clock);
      bus <= '0;
      #1;
      v2 = rdata;
      chk("shared_first", {1'b0, v}, {1'b0, a});
      chk("shared_second", {1'b0, v2}, 9'h0a6);
      wr(SPRF_ADDR_STA, 8'h02);
      chk("baud_ratio", {4'h0, baud_ratio}, 9'd8);
      rchk("status_a", SPRF_ADDR_STA, 8'h22);
      wr(SPRF_ADDR_STA, 8'h00);
      chk("baud_ratio", {4'h0, baud_ratio}, 9'd16);
      line.lat = 20;
      wr(SPRF_ADDR_CTB, 8'h49);
      chk("tx_pin_own", {8'h00, tx_pin_own}, 9'h001);
      a = 8'($random(seed));
      b = 8'($random(seed));
      wr(SPRF_ADDR_DATA, a);
      wait_tx(1);
      wr(SPRF_ADDR_DATA, b);
      rchk("status_a", SPRF_ADDR_STA, 8'h00);
      wr(SPRF_ADDR_DATA, ~b);
      wr(SPRF_ADDR_CTB, 8'h40);
      chk("tx_pin_own", {8'h00, tx_pin_own}, 9'h001);
      wait_tx(2);
      wait_tx(0);
      chk("tx_count", 9'(line.tx_seen.size()), 9'd2);
      // Eight-bit characters: the ninth bit from control B is not sent
      chk("tx_first", line.tx_seen[0], {1'b0, a});
      chk("tx_second", line.tx_seen[1], {1'b0, b});
      rchk("status_a", SPRF_ADDR_STA, 8'h60);
      chk("irq_tx_done", {8'h00, irq_tx_done}, 9'h000);
      @(posedge clock);
      global_irq_en <= 1'b1;
      #1;
      chk("irq_tx_done", {8'h00, irq_tx_done}, 9'h001);
      @(posedge clock);
      irq_ack_txdone <= 1'b1;
      @(posedge clock);
      irq_ack_txdone <= 1'b0;
      rchk("status_a", SPRF_ADDR_STA, 8'h20);
      // Two frames fill the buffer, a third waits, then a new start bit overruns
      wr(SPRF_ADDR_CTB, 8'h90);
      chk("rx_pin_own", {8'h00, rx_pin_own}, 9'h001);
      for (int i = 0; i < 3; i++) begin
         rxd[i] = {1'b0, 8'($random(seed))};
         line.send_frame(rxd[i], i != 0, i == 0);
      end
      line.start_bit();
      repeat (3) @(posedge clock);
      #1;
      chk("irq_rx_done", {8'h00, irq_rx_done}, 9'h001);
      for (int i = 0; i < 3; i++) begin
         rchk("status_a", SPRF_ADDR_STA, (i == 0) ? 8'hbc : 8'ha0);
         rchk("ninth_bit", SPRF_ADDR_CTB, {6'h24, rxd[i][8], 1'b0});
         rchk("rx_data", SPRF_ADDR_DATA, rxd[i][7:0]);
      end
      rchk("status_a", SPRF_ADDR_STA, 8'h20);
      wr(SPRF_ADDR_SHARED, 8'ha4);
      line.send_frame(9'h0ff, 1'b1, 1'b0);
      repeat (3) @(posedge clock);
      rchk("rx_short", SPRF_ADDR_DATA, 8'h7f);
      wr(SPRF_ADDR_STA, 8'h01);
      line.send_frame(9'h055, 1'b0, 1'b0);
      line.send_frame(9'h0aa, 1'b1, 1'b0);
      repeat (3) @(posedge clock);
      rchk("status_a", SPRF_ADDR_STA, 8'ha1);
      rchk("rx_data", SPRF_ADDR_DATA, 8'h2a);
      line.send_frame(9'h0aa, 1'b1, 1'b0);
      repeat (3) @(posedge clock);
      wr(SPRF_ADDR_CTB, 8'h20);
      chk("rx_pin_own", {8'h00, rx_pin_own}, 9'h000);
      rchk("status_a", SPRF_ADDR_STA, 8'h21);
      chk("irq_tx_empty", {8'h00, irq_tx_empty}, 9'h001);
      @(posedge clock);
      global_irq_en <= 1'b0;
      #1;
      chk("irq_tx_empty", {8'h00, irq_tx_empty}, 9'h000);
      final_report();
   end
endmodule
